// file: src/cam_defines.svh
`ifndef CAM_DEFINES_SVH
`define CAM_DEFINES_SVH

// register offsets on the special function register port
`define CAM_CTRL_ADDR     8'hD8
`define CAM_MCTL_ADDR     8'hD9
`define CAM_MODE_BASE     8'hDA
`define CAM_CNT_LO_ADDR   8'hE9
`define CAM_CNT_HI_ADDR   8'hF9
`define CAM_CMP_LO_BASE   8'hEA
`define CAM_CMP_HI_BASE   8'hFA

// counter mode control fields
`define CAM_MCTL_IDLE_BIT 7
`define CAM_MCTL_WDT_BIT  6
`define CAM_MCTL_SRC_HI   2
`define CAM_MCTL_SRC_LO   1
`define CAM_MCTL_OIE_BIT  0
`define CAM_MCTL_MASK     8'hC7
`define CAM_MCTL_RESET    8'h00

// counter control register fields
`define CAM_CTRL_OVF_BIT  7
`define CAM_CTRL_RUN_BIT  6

// module function control fields
`define CAM_MODE_IRQ_BIT  0
`define CAM_MODE_PWM_BIT  1
`define CAM_MODE_TGL_BIT  2
`define CAM_MODE_MCH_BIT  3
`define CAM_MODE_FALL_BIT 4
`define CAM_MODE_RISE_BIT 5
`define CAM_MODE_COM_BIT  6
`define CAM_MODE_MASK     8'h7F
`define CAM_MODE_RESET    8'h00

// prescaler divide ratios in oscillator cycles
`define CAM_DIV_SLOW      4'hC
`define CAM_DIV_SLOW_DS   4'h6
`define CAM_DIV_FAST      4'h4
`define CAM_DIV_FAST_DS   4'h2

// module that doubles as the watchdog
`define CAM_WDT_MODULE    4

`endif

// file: src/cam_pkg.sv
package cam_pkg;

  typedef enum logic [1:0] {
    CAM_SRC_SLOW,
    CAM_SRC_FAST,
    CAM_SRC_T0_OVF,
    CAM_SRC_EXT
  } cam_src_type;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } cam_sfr_req_type;

endpackage : cam_pkg

// file: src/cam_counter_array.sv
`timescale 1ns/1ps
`include "cam_defines.svh"

module cam_counter_array #(
  parameter int NUM_MODULES = 5
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     srst_i,
  input  wire cam_pkg::cam_sfr_req_type sfr_i,
  output logic [7:0]                    sfr_rdata_o,
  input  wire logic                     double_speed_i,
  input  wire logic                     idle_i,
  input  wire logic                     timer0_ovf_i,
  input  wire logic                     external_count_input_i,
  input  wire logic [NUM_MODULES-1:0]   module_input_pin_i,
  output logic [NUM_MODULES-1:0]        module_output_pin_o,
  output logic                          irq_o,
  output logic                          watchdog_reset_o
);
  import cam_pkg::*;

  if (NUM_MODULES < 5 || NUM_MODULES > 6)
  begin : g_bad_count
    $error("cam_counter_array: NUM_MODULES must be 5 or 6");
  end

  logic [7:0]             mode_ctl;
  logic [7:0]             mode [NUM_MODULES];
  logic [15:0]            cmp [NUM_MODULES];
  logic [15:0]            cnt;
  logic                   run;
  logic                   ovf_flag;
  logic [NUM_MODULES-1:0] evt_flag;
  logic [3:0]             div_cnt;
  logic [3:0]             div_limit;
  logic                   div_tick;
  logic [2:0]             ext_sync;
  logic [NUM_MODULES-1:0] pin_s1;
  logic [NUM_MODULES-1:0] pin_s2;
  logic [NUM_MODULES-1:0] pin_q;
  logic                   cnt_moved;
  logic                   src_tick;
  logic                   count_en;
  logic                   ovf_set;
  logic [NUM_MODULES-1:0] match;
  logic [NUM_MODULES-1:0] cap_ev;
  logic [NUM_MODULES-1:0] evt_set;
  cam_src_type            src;

  assign src = cam_src_type'(mode_ctl[`CAM_MCTL_SRC_HI:`CAM_MCTL_SRC_LO]);

  // prescaler for the internal clock sources
  always_comb
  begin
    if (src == CAM_SRC_SLOW)
      div_limit = double_speed_i ? `CAM_DIV_SLOW_DS : `CAM_DIV_SLOW;
    else
      div_limit = double_speed_i ? `CAM_DIV_FAST_DS : `CAM_DIV_FAST;
  end

  assign div_tick = (div_cnt >= div_limit - 4'h1);

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i || div_tick)
      div_cnt <= 4'h0;
    else
      div_cnt <= div_cnt + 4'h1;
  end

  // pin synchronisers; stage 3 only feeds the edge detectors
  always_ff @(posedge ref_clk_i)
  begin
    ext_sync <= {ext_sync[1:0], external_count_input_i};
    pin_s1   <= module_input_pin_i;
    pin_s2   <= pin_s1;
    pin_q    <= pin_s2;
  end

  always_comb
  begin
    case (src)
      CAM_SRC_SLOW:   src_tick = div_tick;
      CAM_SRC_FAST:   src_tick = div_tick;
      CAM_SRC_T0_OVF: src_tick = timer0_ovf_i;
      default:        src_tick = ext_sync[2] & ~ext_sync[1];
    endcase
  end

  assign count_en = run && src_tick && !(idle_i && mode_ctl[`CAM_MCTL_IDLE_BIT]);
  assign ovf_set  = count_en && (cnt == 16'hFFFF);

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      cnt       <= 16'h0000;
      cnt_moved <= 1'b0;
    end
    else
    begin
      cnt_moved <= count_en;
      if (count_en)
        cnt <= cnt + 16'h0001;
    end
  end

  // per-module match, capture and event detection
  always_comb
  begin
    for (int n = 0; n < NUM_MODULES; n++)
    begin
      match[n]   = cnt_moved && mode[n][`CAM_MODE_COM_BIT] && (cnt == cmp[n]);
      cap_ev[n]  = (mode[n][`CAM_MODE_RISE_BIT] && pin_s2[n] && !pin_q[n])
                || (mode[n][`CAM_MODE_FALL_BIT] && !pin_s2[n] && pin_q[n]);
      evt_set[n] = (match[n] && mode[n][`CAM_MODE_MCH_BIT]) || cap_ev[n];
    end
  end

  // counter mode control register
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      mode_ctl <= `CAM_MCTL_RESET;
    else if (sfr_i.wr && sfr_i.addr == `CAM_MCTL_ADDR)
      mode_ctl <= sfr_i.wdata & `CAM_MCTL_MASK;
  end

  // flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      run      <= 1'b0;
      ovf_flag <= 1'b0;
      evt_flag <= '0;
    end
    else if (sfr_i.wr && sfr_i.addr == `CAM_CTRL_ADDR)
    begin
      run      <= sfr_i.wdata[`CAM_CTRL_RUN_BIT];
      ovf_flag <= sfr_i.wdata[`CAM_CTRL_OVF_BIT] | ovf_set;
      evt_flag <= sfr_i.wdata[NUM_MODULES-1:0] | evt_set;
    end
    else
    begin
      ovf_flag <= ovf_flag | ovf_set;
      evt_flag <= evt_flag | evt_set;
    end
  end

  // module mode and compare/capture registers
  always_ff @(posedge ref_clk_i)
  begin
    for (int n = 0; n < NUM_MODULES; n++)
    begin
      if (srst_i)
      begin
        mode[n] <= `CAM_MODE_RESET;
        cmp[n]  <= 16'h0000;
      end
      else
      begin
        if (sfr_i.wr && sfr_i.addr == `CAM_MODE_BASE + 8'(n))
          mode[n] <= sfr_i.wdata & `CAM_MODE_MASK;
        else if (sfr_i.wr && sfr_i.addr == `CAM_CMP_LO_BASE + 8'(n))
          mode[n][`CAM_MODE_COM_BIT] <= 1'b0;
        else if (sfr_i.wr && sfr_i.addr == `CAM_CMP_HI_BASE + 8'(n))
          mode[n][`CAM_MODE_COM_BIT] <= 1'b1;
        if (cap_ev[n])
          cmp[n] <= cnt;
        else if (sfr_i.wr && sfr_i.addr == `CAM_CMP_LO_BASE + 8'(n))
          cmp[n][7:0] <= sfr_i.wdata;
        else if (sfr_i.wr && sfr_i.addr == `CAM_CMP_HI_BASE + 8'(n))
          cmp[n][15:8] <= sfr_i.wdata;
      end
    end
  end

  // output pins: pwm level or toggle on match
  always_ff @(posedge ref_clk_i)
  begin
    for (int n = 0; n < NUM_MODULES; n++)
    begin
      if (srst_i)
        module_output_pin_o[n] <= 1'b1;
      else if (mode[n][`CAM_MODE_PWM_BIT] && mode[n][`CAM_MODE_COM_BIT])
        module_output_pin_o[n] <= (cnt[7:0] >= cmp[n][15:8]);
      else if (match[n] && mode[n][`CAM_MODE_TGL_BIT])
        module_output_pin_o[n] <= !module_output_pin_o[n];
    end
  end

  // interrupt request and watchdog reset
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      irq_o            <= 1'b0;
      watchdog_reset_o <= 1'b0;
    end
    else
    begin
      irq_o <= (ovf_flag && mode_ctl[`CAM_MCTL_OIE_BIT])
            || |(evt_flag & irq_enables(mode));
      watchdog_reset_o <= mode_ctl[`CAM_MCTL_WDT_BIT] && match[`CAM_WDT_MODULE];
    end
  end

  function automatic logic [NUM_MODULES-1:0] irq_enables(input logic [7:0] m [NUM_MODULES]);
    logic [NUM_MODULES-1:0] e;
    e = '0;
    for (int n = 0; n < NUM_MODULES; n++)
      e[n] = m[n][`CAM_MODE_IRQ_BIT];
    return e;
  endfunction : irq_enables

  // register read port, data one cycle after the strobe
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      sfr_rdata_o <= 8'h00;
    else if (sfr_i.rd)
    begin
      sfr_rdata_o <= 8'h00;
      if (sfr_i.addr == `CAM_MCTL_ADDR)
        sfr_rdata_o <= mode_ctl;
      else if (sfr_i.addr == `CAM_CTRL_ADDR)
        sfr_rdata_o <= 8'({ovf_flag, run, 6'h00}) | 8'(evt_flag);
      else if (sfr_i.addr == `CAM_CNT_LO_ADDR)
        sfr_rdata_o <= cnt[7:0];
      else if (sfr_i.addr == `CAM_CNT_HI_ADDR)
        sfr_rdata_o <= cnt[15:8];
      else
        for (int n = 0; n < NUM_MODULES; n++)
        begin
          if (sfr_i.addr == `CAM_MODE_BASE + 8'(n))
            sfr_rdata_o <= mode[n];
          if (sfr_i.addr == `CAM_CMP_LO_BASE + 8'(n))
            sfr_rdata_o <= cmp[n][7:0];
          if (sfr_i.addr == `CAM_CMP_HI_BASE + 8'(n))
            sfr_rdata_o <= cmp[n][15:8];
        end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  div_range_a: assert property ($stable(div_limit) |-> div_cnt < div_limit)
    else $error("prescaler count out of range");
  slow_ratio_a: assert property ((div_tick && src == CAM_SRC_SLOW && !double_speed_i)
    |=> (!div_tick || div_limit != `CAM_DIV_SLOW)[*8])
    else $error("slow prescaler ticked too early");
  idle_halt_a: assert property (idle_i && mode_ctl[`CAM_MCTL_IDLE_BIT] |=> $stable(cnt))
    else $error("counter moved during idle stop");
  ovf_flag_a: assert property (ovf_set |=> ovf_flag && cnt == 16'h0000)
    else $error("overflow did not set the flag");
  ovf_irq_a: assert property (ovf_flag && mode_ctl[`CAM_MCTL_OIE_BIT] |=> irq_o)
    else $error("overflow interrupt missing");
  match_flag_a: assert property (match[0] && mode[0][`CAM_MODE_MCH_BIT] |=> evt_flag[0])
    else $error("match did not set event flag");
  toggle_out_a: assert property (match[0] && mode[0][`CAM_MODE_TGL_BIT]
    && !mode[0][`CAM_MODE_PWM_BIT] |=> module_output_pin_o[0] != $past(module_output_pin_o[0]))
    else $error("output did not toggle on match");
  capture_copy_a: assert property (cap_ev[0] |=> cmp[0] == $past(cnt) && evt_flag[0])
    else $error("capture did not copy the counter");
  cmp_enable_a: assert property (sfr_i.wr && sfr_i.addr == `CAM_CMP_HI_BASE
    |=> mode[0][`CAM_MODE_COM_BIT])
    else $error("high compare write did not enable comparator");
  wdt_reset_a: assert property (mode_ctl[`CAM_MCTL_WDT_BIT] && match[`CAM_WDT_MODULE]
    |=> watchdog_reset_o)
    else $error("watchdog match gave no reset");
  reset_clear_a: assert property (@(posedge ref_clk_i) disable iff (1'b0)
    srst_i |=> mode_ctl == 8'h00 && mode[0] == 8'h00)
    else $error("reset left mode bits set");

  cover_ovf_c:  cover property (ovf_set);
  cover_cap_c:  cover property (cap_ev[1]);
  cover_toggle_c: cover property (match[2] && mode[2][`CAM_MODE_TGL_BIT]);
  cover_wdt_c:  cover property (watchdog_reset_o);

endmodule : cam_counter_array

// file: verif/cam_pin_model.sv
`timescale 1ns/1ps
module cam_pin_model (
  input  wire logic       ref_clk_i,
  output logic            ext_o,
  output logic [4:0]      pin_o
);
  // pins idle high as with the port pull-ups
  initial
  begin
    ext_o = 1'b1;
    pin_o = 5'h1F;
  end
  // count pin edges spaced 17 cycles, well under the osc/8 ceiling
  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      @(negedge ref_clk_i);
      ext_o = 1'b0;
      repeat (8) @(negedge ref_clk_i);
      ext_o = 1'b1;
      repeat (8) @(negedge ref_clk_i);
    end
  endtask : ext_pulses
  task automatic set_pin(input int m, input logic v);
    @(negedge ref_clk_i);
    pin_o[m] = v;
    repeat (6) @(negedge ref_clk_i);
  endtask : set_pin
endmodule : cam_pin_model

// file: verif/testbench.sv
`timescale 1ns/1ps
`include "cam_defines.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module testbench;
  import cam_pkg::*;
  localparam logic [7:0] cm = `CAM_MCTL_ADDR, cc = `CAM_CTRL_ADDR, mb = `CAM_MODE_BASE;
  localparam logic [7:0] lb = `CAM_CMP_LO_BASE, hb = `CAM_CMP_HI_BASE;
  localparam logic [7:0] clo = `CAM_CNT_LO_ADDR, chi = `CAM_CNT_HI_ADDR;
  logic            ref_clk_i, srst_i, double_speed_i, idle_i, timer0_ovf_i;
  logic            irq_o, watchdog_reset_o, ext_w;
  logic [4:0]      pin_w, out_w;
  logic [7:0]      sfr_rdata_o;
  cam_sfr_req_type sfr_i;
  logic [31:0]     seed = 32'd94663;
  int              n_fail = 0, comparisons = 0, wd_pulses = 0;

  cam_counter_array i_cam_counter_array (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .sfr_i(sfr_i), .sfr_rdata_o(sfr_rdata_o),
    .double_speed_i(double_speed_i), .idle_i(idle_i), .timer0_ovf_i(timer0_ovf_i),
    .external_count_input_i(ext_w), .module_input_pin_i(pin_w),
    .module_output_pin_o(out_w), .irq_o(irq_o), .watchdog_reset_o(watchdog_reset_o));
  cam_pin_model i_cam_pin_model (.ref_clk_i(ref_clk_i), .ext_o(ext_w), .pin_o(pin_w));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) if (watchdog_reset_o === 1'b1) wd_pulses++;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int div(logic f, logic ds);
    return f ? (ds ? 2 : 4) : (ds ? 6 : 12);
  endfunction : div
  // mode field j: bit 0 falling enable, bit 1 rising enable
  function automatic logic [7:0] hit(int j, logic r);
    return r ? 8'((j >> 1) & 1) : 8'(j & 1);
  endfunction : hit

  task automatic finish_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    sfr_i = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge ref_clk_i);
    sfr_i.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    sfr_i = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge ref_clk_i);
    sfr_i.rd = 1'b0;
    d = sfr_rdata_o;
  endtask : rd
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(n, e, d)
  endtask : rchk
  task automatic rcnt(output logic [15:0] c);
    rd(clo, c[7:0]);
    rd(chi, c[15:8]);
  endtask : rcnt
  // low counter byte sampled at two edges exactly w cycles apart
  task automatic meas(input int w, output logic [7:0] dl);
    logic [7:0] x0;
    logic [7:0] x1;
    rd(clo, x0);
    repeat (w - 2) @(negedge ref_clk_i);
    rd(clo, x1);
    dl = x1 - x0;
  endtask : meas
  task automatic t0(input int n);
    repeat (n)
    begin
      @(negedge ref_clk_i);
      timer0_ovf_i = 1'b1;
      @(negedge ref_clk_i);
      timer0_ovf_i = 1'b0;
      repeat (3) @(negedge ref_clk_i);
    end
  endtask : t0

  initial
  begin
    #3_200_000;
    n_fail++;
    finish_test();
  end

  initial
  begin
    logic [7:0]  d, a, b, h;
    logic [15:0] c0, c1;
    logic        p;
    int          k, j, m, n;
    sfr_i = '0;
    double_speed_i = 1'b0;
    idle_i = 1'b0;
    timer0_ovf_i = 1'b0;
    srst_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    srst_i = 1'b0;
    `CHK("pins", 5'h1F, out_w)
    rchk("mode_ctl", cm, 8'h00);
    for (k = 0; k < 5; k++) rchk("mode", mb + 8'(k), 8'h00);
    rchk("unmapped", 8'h00, 8'h00);
    for (k = 0; k < 10; k++)
    begin
      d = rnd();
      wr(cm, d);
      rchk("mode_ctl_rw", cm, d & `CAM_MCTL_MASK);
      wr(mb + 8'(k % 5), ~d);
      rchk("mode_rw", mb + 8'(k % 5), ~d & `CAM_MODE_MASK);
    end
    for (k = 0; k < 5; k++) wr(mb + 8'(k), 8'h00);
    wr(cc, 8'h40);
    for (k = 0; k < 4; k++)
    begin
      double_speed_i = k[0];
      wr(cm, {6'h00, k[1], 1'b0});
      meas(120, d);
      `CHK("rate", 8'(120 / div(k[1], k[0])), d)
    end
    double_speed_i = 1'b0;
    idle_i = 1'b1;
    wr(cm, 8'h82);
    meas(120, d);
    `CHK("idle_stop", 8'h00, d)
    wr(cm, 8'h02);
    meas(120, d);
    `CHK("idle_run", 8'd30, d)
    idle_i = 1'b0;
    n = rnd() % 6 + 1;
    wr(cm, 8'h04);
    rd(clo, a);
    t0(n);
    rd(clo, b);
    `CHK("t0_count", 8'(n), 8'(b - a))
    wr(cm, 8'h06);
    rd(clo, a);
    i_cam_pin_model.ext_pulses(n);
    rd(clo, b);
    `CHK("ext_count", 8'(n), 8'(b - a))
    for (j = 0; j < 6; j++)
    begin
      m = j % 5;
      wr(cm, (j == 4) ? 8'h44 : 8'h04);
      wr(cc, 8'h40);
      rcnt(c0);
      c1 = c0 + 16'd2;
      wr(mb + 8'(m), 8'h4D);
      wr(lb + 8'(m), c1[7:0]);
      rchk("com_clr", mb + 8'(m), 8'h0D);
      wr(hb + 8'(m), c1[15:8]);
      rchk("com_set", mb + 8'(m), 8'h4D);
      p = out_w[m];
      wd_pulses = 0;
      t0(3);
      `CHK("toggle", ~p, out_w[m])
      `CHK("irq", 1'b1, irq_o)
      `CHK("wdog", int'(j == 4), wd_pulses)
      rchk("match_flag", cc, 8'h40 | (8'h01 << m));
      wr(mb + 8'(m), 8'h00);
      wr(cc, 8'h40);
      repeat (2) @(negedge ref_clk_i);
      `CHK("irq_clr", 1'b0, irq_o)
    end
    wr(cm, 8'h04);
    for (j = 1; j < 4; j++)
    begin
      m = rnd() % 5;
      wr(mb + 8'(m), 8'(j << 4));
      for (k = 0; k < 2; k++)
      begin
        wr(cc, 8'h40);
        t0(1);
        rcnt(c0);
        i_cam_pin_model.set_pin(m, k[0]);
        rchk("cap_flag", cc, 8'h40 | (hit(j, k[0]) << m));
        if (hit(j, k[0]) == 8'h01)
        begin
          rd(lb + 8'(m), a);
          rd(hb + 8'(m), b);
          `CHK("cap_val", c0, {b, a})
        end
      end
      wr(mb + 8'(m), 8'h00);
    end
    rcnt(c0);
    h = c0[7:0] + 8'd1;
    wr(lb + 8'd2, 8'h00);
    wr(hb + 8'd2, h);
    wr(mb + 8'd2, 8'h42);
    for (k = 0; k < 2; k++)
    begin
      repeat (2) @(negedge ref_clk_i);
      `CHK("pwm", (c0[7:0] + 8'(k) >= h), out_w[2])
      t0(1);
    end
    // timer 0 ticks on every edge until the counter wraps to zero
    wr(cm, 8'h05);
    wr(cc, 8'h40);
    rcnt(c0);
    @(negedge ref_clk_i);
    timer0_ovf_i = 1'b1;
    repeat (32'h1_0000 - c0) @(negedge ref_clk_i);
    timer0_ovf_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    `CHK("ovf_irq", 1'b1, irq_o)
    rchk("ovf_flag", cc, 8'hC0);
    rchk("wrapped", clo, 8'h00);
    finish_test();
  end
endmodule : testbench
